// >>> core/clock_distribution_output_control.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module clock_distribution_output_control import clkdist_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_input_a,
  input wire logic ref_input_b,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic serial_latch_enable,
  input wire logic sync_n,
  input wire logic global_output_enable_pin,
  output logic [NUM_CH-1:0] clk_out,
  output logic [NUM_CH-1:0] clk_off,
  output logic [NUM_CH*DLY_PS_W-1:0] channel_delay_ps
);

  typedef struct packed {
    logic [PIN_CNT-1:0] pin_s1;
    logic [PIN_CNT-1:0] pin_s2;
    logic [PIN_CNT-1:0] pin_prev;
    ch_cfg_t [NUM_CH-1:0] cfg;
    logic gen;
    logic refsel;
    logic [WORD_W-1:0] shift;
    sync_state_t sst;
    logic [2:0] scnt;
    logic [NUM_CH-1:0][DIV_W-1:0] divcnt;
    logic [NUM_CH-1:0] clk_out;
    logic [NUM_CH-1:0] clk_off;
    logic [NUM_CH-1:0][DLY_PS_W-1:0] dly_ps;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // a divide value below two acts as two, so the output still toggles
  function automatic logic [DIV_W-1:0] eff_div(input logic [DIV_W-1:0] d);
    eff_div = (d < 8'h02) ? 8'h02 : d;
  endfunction

  // delay code to picoseconds
  function automatic logic [DLY_PS_W-1:0] delay_ps(input logic [DLY_W-1:0] c);
    delay_ps = DLY_PS_W'(int'(c) * DLY_STEP_PS);
  endfunction

  // one register write, shared by the serial port and the bus
  function automatic state_t apply_wr(input state_t st, input logic [3:0] idx, input logic [DATA_W-1:0] d);
    state_t r;
    r = st;
    if (idx == REG_IDX_RESET && d[F_RESET_BIT]) begin
      // other bits of this word are ignored
      r.cfg = {NUM_CH{CH_CFG_RST}};
      r.gen = GEN_RST;
      r.refsel = REFSEL_RST;
    end else if (idx <= REG_IDX_CH_LAST) begin
      r.cfg[idx[2:0]] = ch_cfg_t'(d[F_PATH_BIT:F_DLY_LSB]);
    end else if (idx == REG_IDX_GLOBAL) begin
      r.gen = d[F_GEN_BIT];
      r.refsel = d[F_REFSEL_BIT];
    end
    apply_wr = r;
  endfunction

  // register read image
  function automatic logic [31:0] read_word(input state_t st, input logic [3:0] idx);
    read_word = 32'h0;
    if (idx <= REG_IDX_CH_LAST) begin
      read_word = {18'h0, st.cfg[idx[2:0]]};
    end else if (idx == REG_IDX_GLOBAL) begin
      read_word = {30'h0, st.refsel, st.gen};
    end else if (idx == REG_IDX_STATUS) begin
      read_word = {26'h0, st.sst, st.pin_s2[PIN_GOE], st.pin_s2[PIN_SYNC_N], st.refsel, st.gen};
    end
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[7:6] == 2'h0) &&
              ((a[5:2] <= REG_IDX_CH_LAST) || (a[5:2] == REG_IDX_GLOBAL) || (a[5:2] == REG_IDX_STATUS));
  endfunction

  logic ref_lvl;
  logic ref_prev;
  logic dist_edge;
  logic sclk_rise;
  logic le_rise;
  logic sync_low;
  logic goe_high;
  logic div_hold;
  logic release_now;
  logic div_lvl;
  logic chan_lvl;
  logic chan_off;
  logic [DIV_W-1:0] ediv;

  // all state advances here; registered once below
  always_comb begin
    s_next = s_reg;
    ediv = 8'h02;
    div_lvl = 1'b0;
    chan_lvl = 1'b0;
    chan_off = 1'b1;

    // pins pass two flops; edges use stage two against its delayed copy
    s_next.pin_s1 = {global_output_enable_pin, sync_n, serial_latch_enable, serial_data_in,
                     serial_clock, ref_input_b, ref_input_a};
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_prev = s_reg.pin_s2;

    // selected reference is the distribution clock
    ref_lvl = s_reg.refsel ? s_reg.pin_s2[PIN_REFB] : s_reg.pin_s2[PIN_REFA];
    ref_prev = s_reg.refsel ? s_reg.pin_prev[PIN_REFB] : s_reg.pin_prev[PIN_REFA];
    dist_edge = ref_lvl & ~ref_prev;
    sclk_rise = s_reg.pin_s2[PIN_SCLK] & ~s_reg.pin_prev[PIN_SCLK];
    le_rise = s_reg.pin_s2[PIN_SLE] & ~s_reg.pin_prev[PIN_SLE];
    sync_low = ~s_reg.pin_s2[PIN_SYNC_N];
    goe_high = s_reg.pin_s2[PIN_GOE];

    // serial shifter, msb first, only while latch enable is low
    if (sclk_rise && !s_reg.pin_s2[PIN_SLE]) begin
      s_next.shift = {s_reg.shift[WORD_W-2:0], s_reg.pin_s2[PIN_SDATA]};
    end

    // apb: ready in the first cycle of the access phase, no wait states
    // error flag stands with pready only; a refused read shows zero
    s_next.pready = psel & ~penable;
    s_next.pslverr = psel & ~penable & ~addr_ok(paddr);
    if (psel && !penable) begin
      s_next.prdata = addr_ok(paddr) ? read_word(s_reg, paddr[5:2]) : 32'h0;
    end
    if (psel && penable && s_reg.pready && pwrite && addr_ok(paddr)) begin
      s_next = apply_wr(s_next, paddr[5:2], pwdata[DATA_W-1:0]);
    end
    // serial load applied last, so it wins a same-cycle clash
    if (le_rise) begin
      s_next = apply_wr(s_next, s_reg.shift[ADDR_W-1:0], s_reg.shift[WORD_W-1:ADDR_W]);
    end

    // sync sequencer, counted in distribution clock edges
    release_now = 1'b0;
    if (dist_edge) begin
      case (s_reg.sst)
        SYNC_RUN: begin
          if (sync_low) begin
            s_next.sst = SYNC_ENTER;
            s_next.scnt = 3'h1;
          end
        end
        SYNC_ENTER: begin
          if (s_reg.scnt == SYNC_WAIT_CYCLES) begin
            s_next.sst = SYNC_HELD;
          end else begin
            s_next.scnt = s_reg.scnt + 3'h1;
          end
        end
        SYNC_HELD: begin
          if (!sync_low) begin
            s_next.sst = SYNC_LEAVE;
            s_next.scnt = 3'h1;
          end
        end
        SYNC_LEAVE: begin
          if (s_reg.scnt == SYNC_WAIT_CYCLES) begin
            s_next.sst = SYNC_RUN;
            release_now = 1'b1;
          end else begin
            s_next.scnt = s_reg.scnt + 3'h1;
          end
        end
        default: begin
          s_next.sst = SYNC_RUN;
        end
      endcase
    end
    div_hold = (s_reg.sst == SYNC_HELD) || (s_reg.sst == SYNC_LEAVE);

    // per-channel divider, gating and delay
    for (int i = 0; i < NUM_CH; i++) begin
      ediv = eff_div(s_reg.cfg[i].div);
      if (release_now || div_hold) begin
        // all counters restart from zero, first level high together
        s_next.divcnt[i] = 8'h00;
      end else if (dist_edge) begin
        s_next.divcnt[i] = (9'(s_reg.divcnt[i]) + 9'h001 >= 9'(ediv)) ? 8'h00 : s_reg.divcnt[i] + 8'h01;
      end
      div_lvl = ~div_hold && (s_reg.divcnt[i] < (ediv >> 1));
      // bypass follows the reference and never sees sync
      chan_lvl = s_reg.cfg[i].path_div ? div_lvl : ref_lvl;
      chan_off = ~s_reg.cfg[i].en | ~s_reg.gen;
      s_next.clk_off[i] = chan_off;
      s_next.clk_out[i] = ~chan_off & goe_high & chan_lvl;
      s_next.dly_ps[i] = delay_ps(s_reg.cfg[i].dly);
    end
  end

  // single state register; pins reset high where pulled up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.pin_s1 <= PIN_RST;
      s_reg.pin_s2 <= PIN_RST;
      s_reg.pin_prev <= PIN_RST;
      s_reg.cfg <= {NUM_CH{CH_CFG_RST}};
      s_reg.gen <= GEN_RST;
      s_reg.refsel <= REFSEL_RST;
      s_reg.sst <= SYNC_RUN;
      s_reg.clk_off <= {NUM_CH{1'b1}};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign clk_out = s_reg.clk_out;
  assign clk_off = s_reg.clk_off;
  assign channel_delay_ps = s_reg.dly_ps;

endmodule

// >>> core/clkdist_pkg.sv
package clkdist_pkg;
  localparam int NUM_CH = 8;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 28;
  localparam int DLY_W = 4;
  localparam int DIV_W = 8;
  localparam int DLY_PS_W = 12;
  localparam int DLY_STEP_PS = 150;
  localparam int DLY_MAX_PS = 2250;
  localparam logic [2:0] SYNC_WAIT_CYCLES = 3'h4;

  // field positions inside a register's data field
  localparam int F_DLY_LSB = 0;
  localparam int F_DIV_LSB = 4;
  localparam int F_EN_BIT = 12;
  localparam int F_PATH_BIT = 13;
  localparam int F_RESET_BIT = 27;
  localparam int F_GEN_BIT = 0;
  localparam int F_REFSEL_BIT = 1;

  // register indices; byte address is index times four
  localparam logic [3:0] REG_IDX_CH_LAST = 4'h7;
  localparam logic [3:0] REG_IDX_RESET = 4'h0;
  localparam logic [3:0] REG_IDX_GLOBAL = 4'he;
  localparam logic [3:0] REG_IDX_STATUS = 4'hf;

  // pin sampling slots
  localparam int PIN_REFA = 0;
  localparam int PIN_REFB = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDATA = 3;
  localparam int PIN_SLE = 4;
  localparam int PIN_SYNC_N = 5;
  localparam int PIN_GOE = 6;
  localparam int PIN_CNT = 7;

  // reset values; pulled-up pins start high
  localparam logic [6:0] PIN_RST = 7'h60;
  localparam logic [13:0] CH_CFG_RST = 14'h0010;
  localparam logic GEN_RST = 1'b1;
  localparam logic REFSEL_RST = 1'b0;

  typedef struct packed {
    logic path_div;
    logic en;
    logic [DIV_W-1:0] div;
    logic [DLY_W-1:0] dly;
  } ch_cfg_t;

  typedef enum logic [1:0] {SYNC_RUN, SYNC_ENTER, SYNC_HELD, SYNC_LEAVE} sync_state_t;
endpackage

// >>> core/README_unused.sv
`timescale 1ns/100ps

// >>> bench/clkdist_checker.sv
`timescale 1ns/100ps
module clkdist_checker import clkdist_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_output_enable_pin,
  input wire logic [NUM_CH-1:0] clk_out,
  input wire logic [NUM_CH-1:0] clk_off,
  input wire logic [NUM_CH*DLY_PS_W-1:0] channel_delay_ps
);
  logic dly_ok;
  logic [DLY_PS_W-1:0] lane;
  // every lane a whole step count within range
  always_comb begin
    dly_ok = 1'b1;
    lane = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      lane = channel_delay_ps[i*DLY_PS_W+:DLY_PS_W];
      if (lane % DLY_STEP_PS != 0 || lane > DLY_MAX_PS) dly_ok = 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_next_a: assert property (psel && !penable |=> pready) else $error("no wait-free answer");
  ready_once_a: assert property (pready |=> !pready) else $error("pready held");
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  err_map_a: assert property (psel && !penable && paddr[5:2] inside {[4'h8:4'hd]} |=> pslverr) else $error("no error");
  err_read_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  off_low_a: assert property ((clk_off & clk_out) == '0) else $error("off channel high");
  pin_low_a: assert property ((!global_output_enable_pin) [*6] |-> clk_out == '0) else $error("pin ignored");
  dly_step_a: assert property (dly_ok) else $error("delay off step");
endmodule
bind clock_distribution_output_control clkdist_checker chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .global_output_enable_pin, .clk_out, .clk_off, .channel_delay_ps);

// >>> bench/host_model.sv
`timescale 1ns/100ps
module host_model (
  input wire logic pclk,
  output logic ref_input_a,
  output logic ref_input_b,
  output logic serial_clock,
  output logic serial_data_in,
  output logic serial_latch_enable,
  output logic sync_n,
  output logic global_output_enable_pin
);
  // serial lines idle low, pulled-up pins idle high
  initial begin
    {ref_input_a, ref_input_b, serial_clock, serial_data_in, serial_latch_enable} = 5'h0;
    {sync_n, global_output_enable_pin} = 2'h3;
  end
  // slow references so the sampler sees each level
  always begin
    repeat (5) @(posedge pclk);
    ref_input_a <= ~ref_input_a;
  end
  always begin
    repeat (7) @(posedge pclk);
    ref_input_b <= ~ref_input_b;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // word is data then address, msb first; gap sets the pace
  task automatic send_word(input logic [31:0] w, input int gap);
    for (int i = 31; i >= 0; i--) begin
      serial_data_in <= w[i];
      hold(gap);
      serial_clock <= 1'b1;
      hold(gap);
      serial_clock <= 1'b0;
    end
    serial_latch_enable <= 1'b1;
    hold(gap);
    serial_latch_enable <= 1'b0;
    serial_data_in <= 1'b0;
    hold(gap);
  endtask
endmodule

// >>> bench/clock_distribution_output_control_tb.sv
`timescale 1ns/100ps
module clock_distribution_output_control_tb import clkdist_pkg::*; ;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ref_input_a, ref_input_b, serial_clock, serial_data_in;
  logic serial_latch_enable, sync_n, global_output_enable_pin, prev;
  logic [NUM_CH-1:0] clk_out, clk_off;
  logic [NUM_CH*DLY_PS_W-1:0] channel_delay_ps;
  logic [3:0] d [NUM_CH];
  logic [32:0] e;
  logic [32:0] exp_q [$];
  int err_total = 0, checks = 0, cyc = 0, hi, tog;
  integer seed = 32'hf55bddb6;
  clock_distribution_output_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ref_input_a, .ref_input_b, .serial_clock, .serial_data_in, .serial_latch_enable,
    .sync_n, .global_output_enable_pin, .clk_out, .clk_off, .channel_delay_ps);
  host_model host (.pclk, .ref_input_a, .ref_input_b, .serial_clock, .serial_data_in, .serial_latch_enable,
    .sync_n, .global_output_enable_pin);
  initial forever #4 pclk = ~pclk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; note holds {pslverr, prdata}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] x);
    exp_q.push_back(x);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // pops the oldest note when a transfer completes; hangs end here too
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("pslverr", 32'(pslverr), 32'(e[32]));
      if (!pwrite) check("prdata", prdata, e[31:0]);
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) apb(1'b0, 8'(i * 4), 32'h0, 33'h10);
    apb(1'b0, 8'h38, 32'h0, 33'h1);
    apb(1'b0, 8'h3c, 32'h0, 33'hd);
    check("off", 32'(clk_off), 32'hff);
    apb(1'b0, 8'(32 + 4 * ($unsigned($random(seed)) % 6)), 32'h0, 33'h100000000);
    apb(1'b1, 8'h34, 32'hffffffff, 33'h100000000);
    // random codes, with zero and full scale at the ends
    for (int i = 0; i < 8; i++) begin
      d[i] = i == 0 ? 4'h0 : i == 7 ? 4'hf : 4'($random(seed));
      apb(1'b1, 8'(i * 4), {18'h0, 2'b01, 8'h01, d[i]}, 33'h0);
    end
    apb(1'b1, 8'h38, 32'h1, 33'h0);
    tick(6);
    for (int i = 0; i < 8; i++) check("delay", 32'(channel_delay_ps[i*12+:12]), d[i] * 150);
    check("on", 32'(clk_off), 32'h0);
    host.global_output_enable_pin <= 1'b0;
    tick(8);
    check("pin low", 32'({clk_off, clk_out}), 32'h0);
    host.global_output_enable_pin <= 1'b1;
    apb(1'b1, 8'h0c, 32'h10, 33'h0);
    tick(6);
    check("ch3 off", 32'(clk_off), 32'h8);
    host.send_word(32'he, 3);
    tick(6);
    check("global off", 32'(clk_off), 32'hff);
    host.send_word(32'h3e, 6);
    apb(1'b0, 8'h3c, 32'h0, 33'hf);
    host.send_word(32'h8ffffff0, 4);
    tick(6);
    apb(1'b0, 8'h0c, 32'h0, 33'h10);
    apb(1'b0, 8'h38, 32'h0, 33'h1);
    check("delay7", 32'(channel_delay_ps[95:84]), 32'h0);
    // bypass on 0, divided by 2 and 4 on 1 and 2
    apb(1'b1, 8'h0, 32'h1010, 33'h0);
    apb(1'b1, 8'h4, 32'h3020, 33'h0);
    apb(1'b1, 8'h8, 32'h3040, 33'h0);
    tick(100);
    host.sync_n <= 1'b0;
    tick(80);
    apb(1'b0, 8'h3c, 32'h0, 33'h29);
    hi = 0;
    tog = 0;
    for (int n = 0; n < 100; n++) begin
      prev = clk_out[0];
      @(posedge pclk);
      hi += int'(clk_out[2:1] != 2'b00);
      tog += int'(clk_out[0] != prev);
    end
    check("held low", 32'(hi), 32'h0);
    check("bypass runs", 32'(tog > 0), 32'h1);
    host.sync_n <= 1'b1;
    for (int n = 0; n < 300 && clk_out[2:1] == 2'b00; n++) @(posedge pclk);
    check("rise together", 32'(clk_out[2:1]), 32'h3);
    finish_test();
  end
endmodule
